// File: design/wdrt_defs.svh
/*
  Constants of the watchdog reset timer: register offsets, field positions,
  reset values and timing counts.
  Assumes an 8-bit register port and a 20 MHz bus clock.
*/
`ifndef WDRT_DEFS_SVH
`define WDRT_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define WDRT_ADDR_OPT1   8'h00
`define WDRT_ADDR_OPT2   8'h01
`define WDRT_ADDR_CAUSE  8'h02
`define WDRT_ADDR_STAT   8'h03
`define WDRT_ADDR_MASK   8'h04

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define WDRT_OPT1_EN_BIT   7
`define WDRT_OPT1_TO_BIT   6
`define WDRT_OPT2_CLK_BIT  7
`define WDRT_CAUSE_POR_BIT 7
`define WDRT_CAUSE_WD_BIT  5
`define WDRT_EV_TRIP_BIT   0
`define WDRT_EV_LOCK_BIT   1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define WDRT_OPT1_RST   8'hC0
`define WDRT_OPT2_RST   8'h00
`define WDRT_CAUSE_POR  8'h80
`define WDRT_CAUSE_WD   8'h20

// ----------------------------------------------------------------------
// timing: last counter value before overflow, and reset pulse length
// ----------------------------------------------------------------------
`define WDRT_LPO_SHORT_LAST 18'h0001F
`define WDRT_LPO_LONG_LAST  18'h000FF
`define WDRT_BUS_SHORT_LAST 18'h01FFF
`define WDRT_BUS_LONG_LAST  18'h3FFFF
`define WDRT_HOLD_LAST      3'h7
`define WDRT_LPO_PERIOD_NS  1000000

`endif

// File: design/wdrt_event_irq.sv
/*
  Sticky event flags with write-one-to-clear, a mask, one level interrupt.
  Assumes set and clear strobes are single bus-clock pulses.
*/
`timescale 1ns/1ps
`default_nettype none

module wdrt_event_irq (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic [1:0] ev_set,
  input  wire logic       stat_wr,
  input  wire logic       mask_wr,
  input  wire logic [1:0] wdata,
  output logic      [1:0] stat_q,
  output logic      [1:0] mask_q,
  output logic            irq
);

  // set wins over a clear in the same cycle so no event is lost
  for (genvar i = 0; i < 2; i++) begin : g_flag
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        stat_q[i] <= 1'b0;
      end else if (ev_set[i]) begin
        stat_q[i] <= 1'b1;
      end else if (stat_wr && wdata[i]) begin
        stat_q[i] <= 1'b0;
      end
    end
  end

  // mask: a one lets the flag through
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mask_q <= 2'h0;
    end else if (mask_wr) begin
      mask_q <= wdata;
    end
  end

  assign irq = |(stat_q & mask_q);

endmodule

`default_nettype wire

// File: design/wdrt_pkg.sv
/*
  Types shared by the watchdog reset timer files.
  Assumes nothing of its surroundings.
*/
package wdrt_pkg;

  // run, or drive the system reset pulse
  typedef enum logic [0:0] {
    WDRT_RUN  = 1'b0,
    WDRT_HOLD = 1'b1
  } wdrt_state_t;

  typedef logic [17:0] wdrt_count_t;

endpackage

// File: design/wdrt_sync_edge.sv
/*
  Two-flop synchroniser for the low-power clock with a rising-edge pulse.
  Assumes the input toggles far slower than the bus clock.
*/
`timescale 1ns/1ps
`default_nettype none

module wdrt_sync_edge (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic async_in,
  output logic      rise
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // first stage feeds only the second stage
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise = sync_q & ~last_q;

endmodule

`default_nettype wire

// File: design/wdrt_top.sv
/*
  Watchdog reset timer: write-once option registers, service address,
  overflow counter on bus clock or low-power clock, reset pulse generation,
  reset cause record and an event interrupt.
  Assumes an 8-bit register port with read data one cycle after the strobe,
  a slow low-power clock on lpo_clk, and stop and debug levels from the core.
*/
// Implementation choices: the address-and-strobe port and the register addresses.
// Operation
// - every reset sets watchdog enable bit
// - clearing enable stops counting and resets
// - service write clears counter, cause unchanged
// - overflow of enabled counter resets system
// - clock select zero low-power, one bus
// - timeout select picks short or long
// - defaults low-power clock and long timeout
// - option registers accept one write only
// - first option write clears the counter
// - debug halt holds the counter
// - bus clock stop freezes, then resumes
// - low-power clock stop zeroes counter
// - watchdog reset recorded in cause register
`timescale 1ns/1ps
`default_nettype none
`include "wdrt_defs.svh"

module wdrt_top #(
  parameter logic [17:0] BUS_SHORT_LAST = `WDRT_BUS_SHORT_LAST,
  parameter logic [17:0] BUS_LONG_LAST  = `WDRT_BUS_LONG_LAST
) (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       lpo_clk,
  input  wire logic       stop_mode,
  input  wire logic       debug_halt,
  output logic            system_reset,
  output logic            irq
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  wdrt_pkg::wdrt_state_t state_q;
  wdrt_pkg::wdrt_count_t count_q;
  wdrt_pkg::wdrt_count_t limit;
  logic [7:0]            opt1_q;
  logic [7:0]            opt2_q;
  logic [7:0]            cause_q;
  logic [7:0]            rdata_q;
  logic [2:0]            hold_q;
  logic                  opt1_lock_q;
  logic                  opt2_lock_q;
  logic                  run;
  logic                  enable;
  logic                  bus_sel;
  logic                  long_sel;
  logic                  lpo_rise;
  logic                  tick;
  logic                  wr_opt1;
  logic                  wr_opt2;
  logic                  first1;
  logic                  first2;
  logic                  service;
  logic                  clear_any;
  logic                  trip;
  logic                  refused;
  logic [1:0]            stat;
  logic [1:0]            mask;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  // writes during the reset pulse are dropped: the system is in reset
  assign run      = (state_q == wdrt_pkg::WDRT_RUN);
  assign enable   = opt1_q[`WDRT_OPT1_EN_BIT];
  assign long_sel = opt1_q[`WDRT_OPT1_TO_BIT];
  assign bus_sel  = opt2_q[`WDRT_OPT2_CLK_BIT];
  assign wr_opt1  = run && reg_wr && (reg_addr == `WDRT_ADDR_OPT1);
  assign wr_opt2  = run && reg_wr && (reg_addr == `WDRT_ADDR_OPT2);
  assign first1   = wr_opt1 && !opt1_lock_q;
  assign first2   = wr_opt2 && !opt2_lock_q;
  assign refused  = (wr_opt1 && opt1_lock_q) || (wr_opt2 && opt2_lock_q);

  assign service  = run && reg_wr && (reg_addr == `WDRT_ADDR_CAUSE);

  assign clear_any = service || first1 || first2;

  // ----------------------------------------------------------------------
  // counting clock
  // ----------------------------------------------------------------------
  // the low-power clock is brought in through a synchroniser so the
  // counter and its clear live in one domain and no clear is missed
  wdrt_sync_edge u_lpo (
    .clock    (clock),
    .resetn   (resetn),
    .async_in (lpo_clk),
    .rise     (lpo_rise)
  );

  assign tick = bus_sel ? 1'b1 : lpo_rise;

  always_comb begin
    limit = `WDRT_LPO_LONG_LAST;
    unique case ({bus_sel, long_sel})
      2'b00: limit = `WDRT_LPO_SHORT_LAST;
      2'b01: limit = `WDRT_LPO_LONG_LAST;
      2'b10: limit = BUS_SHORT_LAST;
      2'b11: limit = BUS_LONG_LAST;
    endcase
  end

  // overflow when the last value sees one more tick
  assign trip = run && enable && tick && !clear_any && !stop_mode
                && !debug_halt && (count_q == limit);

  // ----------------------------------------------------------------------
  // watchdog counter
  // ----------------------------------------------------------------------
  // priority: reset pulse, disable, clears, stop, debug, count
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count_q <= 18'h00000;
    end else if (!run) begin
      count_q <= 18'h00000;
    end else if (!enable) begin
      count_q <= 18'h00000;
    // clear takes effect in the counting domain
    end else if (clear_any) begin
      count_q <= 18'h00000;
    end else if (stop_mode && !bus_sel) begin
      count_q <= 18'h00000;
    end else if (debug_halt) begin
      count_q <= count_q;
    end else if (stop_mode) begin
      count_q <= count_q;
    end else if (trip) begin
      count_q <= 18'h00000;
    end else if (tick) begin
      count_q <= count_q + 18'h00001;
    end
  end

  // ----------------------------------------------------------------------
  // reset pulse sequencer
  // ----------------------------------------------------------------------
  // the pulse is a fixed length so the system reset is always seen
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= wdrt_pkg::WDRT_RUN;
      hold_q  <= 3'h0;
    end else begin
      unique case (state_q)
        wdrt_pkg::WDRT_RUN: begin
          hold_q <= 3'h0;
          if (trip) begin
            state_q <= wdrt_pkg::WDRT_HOLD;
          end
        end
        wdrt_pkg::WDRT_HOLD: begin
          hold_q <= hold_q + 3'h1;
          if (hold_q == `WDRT_HOLD_LAST) begin
            state_q <= wdrt_pkg::WDRT_RUN;
          end
        end
      endcase
    end
  end

  assign system_reset = (state_q == wdrt_pkg::WDRT_HOLD);

  // ----------------------------------------------------------------------
  // option registers
  // ----------------------------------------------------------------------
  // any reset restores enable set
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      opt1_q      <= `WDRT_OPT1_RST;
      opt1_lock_q <= 1'b0;
    end else if (!run) begin
      opt1_q      <= `WDRT_OPT1_RST;
      opt1_lock_q <= 1'b0;
    end else if (first1) begin
      opt1_q      <= reg_wdata & `WDRT_OPT1_RST;
      opt1_lock_q <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      opt2_q      <= `WDRT_OPT2_RST;
      opt2_lock_q <= 1'b0;
    end else if (!run) begin
      opt2_q      <= `WDRT_OPT2_RST;
      opt2_lock_q <= 1'b0;
    end else if (first2) begin
      opt2_q      <= {reg_wdata[`WDRT_OPT2_CLK_BIT], 7'h00};
      opt2_lock_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // reset cause
  // ----------------------------------------------------------------------
  // watchdog trip replaces the cause
  // read-only: service writes to this address leave it untouched
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cause_q <= `WDRT_CAUSE_POR;
    end else if (trip) begin
      cause_q <= `WDRT_CAUSE_WD;
    end
  end

  // ----------------------------------------------------------------------
  // events and interrupt
  // ----------------------------------------------------------------------
  // flags survive the watchdog reset pulse so software can inspect them
  wdrt_event_irq u_irq (
    .clock   (clock),
    .resetn  (resetn),
    .ev_set  ({refused, trip}),
    .stat_wr (run && reg_wr && (reg_addr == `WDRT_ADDR_STAT)),
    .mask_wr (run && reg_wr && (reg_addr == `WDRT_ADDR_MASK)),
    .wdata   (reg_wdata[1:0]),
    .stat_q  (stat),
    .mask_q  (mask),
    .irq     (irq)
  );

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  // data stands one cycle after the strobe, zero otherwise and unmapped
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `WDRT_ADDR_OPT1:  rdata_q <= opt1_q;
        `WDRT_ADDR_OPT2:  rdata_q <= opt2_q;
        `WDRT_ADDR_CAUSE: rdata_q <= cause_q;
        `WDRT_ADDR_STAT:  rdata_q <= {6'h00, stat};
        `WDRT_ADDR_MASK:  rdata_q <= {6'h00, mask};
        default:          rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_pulse;
    system_reset [*8] ##1 !system_reset;
  endsequence

  sequence s_bus_run;
    run && enable && bus_sel && !stop_mode && !debug_halt && !clear_any;
  endsequence

  a_reset_enable:
    assert property ($fell(system_reset) |-> enable && !opt1_lock_q)
    else $error("enable not set after watchdog reset");

  a_disabled_quiet:
    assert property (!enable |-> !trip ##1 count_q == 18'h00000)
    else $error("disabled watchdog counted or tripped");

  a_service_clear:
    assert property (service && enable |=> count_q == 18'h00000 && $stable(cause_q))
    else $error("service write did not clear or changed cause");

  a_trip_pulse:
    assert property (trip |=> s_pulse)
    else $error("reset pulse wrong after overflow");

  a_bus_count:
    assert property ((s_bus_run and !trip) |=> count_q == $past(count_q) + 18'h00001)
    else $error("bus clock did not advance the counter");

  a_trip_limit:
    assert property (trip |-> count_q == limit && tick)
    else $error("overflow at wrong count");

  a_reset_defaults:
    assert property ($fell(system_reset) |-> !bus_sel && long_sel)
    else $error("defaults not restored after reset");

  a_lock_once:
    assert property (wr_opt1 && opt1_lock_q |=> $stable(opt1_q) && stat[1])
    else $error("locked option register changed");

  a_first_clear:
    assert property ((first1 || first2) && run |=> count_q == 18'h00000)
    else $error("first option write did not clear");

  a_debug_hold:
    assert property (run && enable && debug_halt && !clear_any && !stop_mode
                     |=> $stable(count_q))
    else $error("counter moved in debug halt");

  a_stop_freeze:
    assert property (run && enable && bus_sel && stop_mode && !clear_any
                     |=> $stable(count_q))
    else $error("counter moved in stop with bus clock");

  a_stop_zero:
    assert property (run && !bus_sel && stop_mode |=> count_q == 18'h00000)
    else $error("counter not zero in stop with low-power clock");

  a_cause_record:
    assert property (trip |=> cause_q == `WDRT_CAUSE_WD)
    else $error("watchdog cause not recorded");

endmodule

`default_nettype wire

// File: test/watchdog_reset_timer_bench.sv
/*
  Self-checking bench of the watchdog reset timer: defaults, write-once options,
  service, overflow, debug and stop behaviour, clock select, status interrupt.
  Assumes the design files under design/ and a 20 MHz bus clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wdrt_defs.svh"

module watchdog_reset_timer_bench;
  // ----------------------------------------------------------------------
  // signals and shortened bus time-outs
  // ----------------------------------------------------------------------
  localparam logic [17:0] SHORT_LAST = 18'h0000F;
  localparam logic [17:0] LONG_LAST  = 18'h0003F;

  logic        clock;
  logic        resetn;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        lpo_clk = 1'b0;
  logic [7:0]  lpo_div = 8'h00;
  logic        stop_mode;
  logic        debug_halt;
  logic        system_reset;
  logic        irq;
  logic [31:0] seed;
  int          failures;
  int          cmp_count;
  int          n;
  int          k;

  wdrt_top #(.BUS_SHORT_LAST(SHORT_LAST), .BUS_LONG_LAST(LONG_LAST)) dut (
    .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lpo_clk(lpo_clk),
    .stop_mode(stop_mode), .debug_halt(debug_halt), .system_reset(system_reset),
    .irq(irq)
  );

  // ----------------------------------------------------------------------
  // clocks
  // ----------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // low-power stand-in runs free at 20 bus cycles a period, so a run stays short
  always @(posedge clock) begin
    if (lpo_div == 8'h09) begin
      lpo_div <= 8'h00;
      lpo_clk <= ~lpo_clk;
    end else begin
      lpo_div <= lpo_div + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction

  // overflow seen a few edges after the last count; slack covers pipeline
  function automatic logic [7:0] in_win(input int cnt, input int lo, input int hi);
    return (cnt >= lo && cnt <= hi) ? 8'h01 : 8'h00;
  endfunction

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // write ends with a one-cycle gap so strobes never collide in one time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    // read data stand for this cycle only: look mid-cycle, where they are settled
    @(negedge clock);
    chk(what, reg_rdata, exp);
    @(posedge clock);
  endtask

  task automatic cfg(input logic [7:0] o2, input logic [7:0] o1);
    wr(`WDRT_ADDR_OPT2, o2);
    wr(`WDRT_ADDR_OPT1, o1);
  endtask

  task automatic quiet(input int cyc, input string what);
    logic seen;
    seen = 1'b0;
    repeat (cyc) begin
      @(posedge clock);
      if (system_reset !== 1'b0) seen = 1'b1;
    end
    chk(what, {7'h00, seen}, 8'h00);
  endtask

  task automatic wait_rst(input int max, output int cnt);
    cnt = 0;
    while (cnt < max && system_reset !== 1'b1) begin
      @(posedge clock);
      cnt++;
    end
    if (system_reset !== 1'b1) begin
      chk("system_reset timeout", {7'h00, system_reset}, 8'h01);
      stop_test();
    end
  endtask

  task automatic pulse;
    int p;
    p = 0;
    while (system_reset === 1'b1 && p < 20) begin
      @(posedge clock);
      p++;
    end
    chk("reset pulse length", p[7:0], 8'h08);
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    resetn     = 1'b0;
    reg_addr   = 8'h00;
    reg_wdata  = 8'h00;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    stop_mode  = 1'b0;
    debug_halt = 1'b0;
    seed       = 32'h74514BAC;
    failures   = 0;
    cmp_count  = 0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rd_chk("opt1", `WDRT_ADDR_OPT1, `WDRT_OPT1_RST);
    rd_chk("opt2", `WDRT_ADDR_OPT2, `WDRT_OPT2_RST);
    rd_chk("cause", `WDRT_ADDR_CAUSE, `WDRT_CAUSE_POR);
    rd_chk("unmapped", 8'h3C, 8'h00);
    // bus clock, short time-out, then a refused second write
    cfg(8'h80, 8'h80);
    seed = lfsr(seed);
    wr(`WDRT_ADDR_OPT1, seed[7:0]);
    rd_chk("opt1 locked", `WDRT_ADDR_OPT1, 8'h80);
    rd_chk("status refused", `WDRT_ADDR_STAT, 8'h02);
    wr(`WDRT_ADDR_MASK, 8'h02);
    chk("irq set", {7'h00, irq}, 8'h01);
    wr(`WDRT_ADDR_STAT, 8'h02);
    chk("irq cleared", {7'h00, irq}, 8'h00);
    // random service intervals and values keep the counter short of overflow
    // services from main flow
    for (k = 0; k < 20; k++) begin
      seed = lfsr(seed);
      wr(`WDRT_ADDR_CAUSE, seed[15:8]);
      quiet(int'(seed[3:0]) % 12, "serviced reset");
    end
    rd_chk("cause kept", `WDRT_ADDR_CAUSE, `WDRT_CAUSE_POR);
    // overflow after one last service
    wr(`WDRT_ADDR_CAUSE, 8'hA5);
    wait_rst(100, n);
    chk("short bus timeout", in_win(n, SHORT_LAST, SHORT_LAST + 3), 8'h01);
    pulse();
    rd_chk("cause after trip", `WDRT_ADDR_CAUSE, `WDRT_CAUSE_WD);
    rd_chk("opt1 after trip", `WDRT_ADDR_OPT1, `WDRT_OPT1_RST);
    rd_chk("status trip", `WDRT_ADDR_STAT, 8'h01);
    chk("irq masked", {7'h00, irq}, 8'h00);
    wr(`WDRT_ADDR_MASK, 8'h03);
    chk("irq trip", {7'h00, irq}, 8'h01);
    rd_chk("mask", `WDRT_ADDR_MASK, 8'h03);
    wr(`WDRT_ADDR_STAT, 8'h01);
    chk("irq trip cleared", {7'h00, irq}, 8'h00);
    // long bus time-out counted from the option write alone
    cfg(8'h80, 8'hC0);
    wait_rst(200, n);
    chk("long bus timeout", in_win(n, LONG_LAST, LONG_LAST + 3), 8'h01);
    pulse();
    // debug halt then stop: counter must hold, not clear
    for (k = 0; k < 2; k++) begin
      cfg(8'h80, 8'h80);
      repeat (6) @(posedge clock);
      if (k == 0) debug_halt <= 1'b1;
      else stop_mode <= 1'b1;
      quiet(40, "reset while held");
      debug_halt <= 1'b0;
      stop_mode  <= 1'b0;
      wait_rst(100, n);
      chk("resumed count", in_win(n, 4, 12), 8'h01);
      pulse();
    end
    // low-power clock, short: stop must restart the count from zero
    cfg(8'h00, 8'h80);
    quiet(400, "low-power count too fast");
    stop_mode <= 1'b1;
    quiet(200, "reset in low-power stop");
    stop_mode <= 1'b0;
    quiet(500, "count not zeroed by stop");
    wait_rst(400, n);
    pulse();
    // defaults: low-power long time-out of 256 ticks
    cfg(8'h00, 8'hC0);
    quiet(4900, "long low-power too early");
    wait_rst(600, n);
    pulse();
    // disabled watchdog never trips
    cfg(8'h00, 8'h00);
    quiet(1000, "disabled reset");
    // second external reset mid-run restores the enable
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rd_chk("opt1 rearmed", `WDRT_ADDR_OPT1, `WDRT_OPT1_RST);
    rd_chk("cause power-on", `WDRT_ADDR_CAUSE, `WDRT_CAUSE_POR);
    stop_test();
  end
endmodule
`default_nettype wire
